/* inc/pbei_pkg.sv */
/*
 * Constants for the pattern bit error injector: register offsets, field
 * positions, reset values, rate limits and the source encoding.
 * Assumes a 32-bit register port addressed in bytes, one word per register.
 */
`default_nettype none

package pbei_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] PBEI_OFS_CTRL   = 8'h00;
    localparam logic [7:0] PBEI_OFS_ROUTE  = 8'h04;
    localparam logic [7:0] PBEI_OFS_RATE   = 8'h08;
    localparam logic [7:0] PBEI_OFS_MIXED  = 8'h0c;
    localparam logic [7:0] PBEI_OFS_SINGLE = 8'h10;
    localparam logic [7:0] PBEI_OFS_STATUS = 8'h14;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int CTRL_SOURCE_LSB  = 1;
    localparam int CTRL_AUXINJ_BIT  = 3;
    localparam int CTRL_SINGLE_BIT  = 4;
    localparam int CTRL_SCAN_BIT    = 5;
    localparam int CTRL_COMBINE_LSB = 6;
    localparam int RATE_MANT_LSB    = 0;
    localparam int RATE_EXP_LSB     = 8;
    localparam int MIXED_EN_BIT     = 0;
    localparam int MIXED_PRBS_BIT   = 1;
    localparam int MIXED_BLOCK_LSB  = 16;
    localparam int STATUS_ROUTE_LSB = 16;
    localparam int STATUS_PEND_LSB  = 24;

    // ------------------------------------------------------------------
    // Limits and reset values
    // ------------------------------------------------------------------
    localparam logic [5:0] ROUTE_MIN      = 6'h01;
    localparam logic [5:0] ROUTE_MAX      = 6'h20;
    localparam logic [3:0] MANT_MIN       = 4'h1;
    localparam logic [3:0] MANT_MAX       = 4'h9;
    localparam logic [3:0] MANT_MAX_EXP3  = 4'h5;
    localparam logic [3:0] EXP_MIN        = 4'h3;
    localparam logic [3:0] EXP_MAX        = 4'hc;
    localparam logic [5:0] ROUTE_RESET    = 6'h01;
    localparam logic [3:0] MANT_RESET     = 4'h1;
    localparam logic [3:0] EXP_RESET      = 4'h6;
    localparam logic [8:0] BLOCK_RESET    = 9'h001;
    localparam logic [3:0] PEND_MAX       = 4'hf;

    // ------------------------------------------------------------------
    // Error timing source
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PBEI_SRC_INTERNAL = 2'b00,
        PBEI_SRC_TRIGGER  = 2'b01,
        PBEI_SRC_GATED    = 2'b10,
        PBEI_SRC_SPARE    = 2'b11
    } pbei_source_type;

endpackage

`default_nettype wire

/* design/pattern_bit_error_injector.sv */
/*
 * Pattern bit error injector: flips single bits in the parallel word that
 * feeds the serialiser, one lane per route.
 * Assumes one word per clock when patValid is high, inputs synchronous to
 * clk, and a register master that never issues read and write together.
 */
// Overview of operation
// [R1] Global enable off means no errors at all, even externally requested ones.
// [R2] Trigger source inserts one error on each rising edge of the aux input.
// [R3] Gated source uses internal slots but drops those seen while aux is low.
// [R4] Source selection only counts when aux input is set for error injection.
// [R5] Continuous versus one-shot applies only to internal or gated source.
// [R6] Continuous mode inserts at the configured rate while enabled.
// [R7] One-shot mode inserts exactly one error per operator request; the code queues combine_reg+1 errors per request.
// [R8] With combined channels one request inserts one error per channel.
// [R9] Each of the 32 parallel lanes is a separate route.
// [R10] Scan mode moves each successive error to the next route.
// [R11] Fixed mode inserts every error into the route numbered 1 to 32.
// [R12] The route number is ignored while scan mode is selected.
// [R13] Route and rate stay writable while disabled and apply once enabled.
// [R14] Rate is x times ten to minus n, x 1..9, n 3..12.
// [R15] With n equal to 3, x is limited to 1..5.
// [R16] Rate is ignored in one-shot mode and with the trigger source.
// [R17] Each error corrupts exactly one bit of the outgoing pattern.
// [R18] Mixed patterns take errors only in the chosen part of the chosen block.
// [R19] A bit is corrupted by inversion; rate gives one error per 10^n/x bits.
// [R20] The aux source drives a clean level; edges trigger, low gates.
`timescale 1ns/1ps
`default_nettype none

module pattern_bit_error_injector
#(
    parameter int LANES = 32                    // Routes per word
)
(
    input  wire logic                clk,          // 25 MHz clock
    input  wire logic                nrst,         // Async reset, active low
    input  wire logic [7:0]          regAddr,      // Register byte address
    input  wire logic [31:0]         regWdata,     // Register write data
    input  wire logic                regWr,        // Write strobe
    input  wire logic                regRd,        // Read strobe
    output logic      [31:0]         regRdata,     // Read data, next cycle
    input  wire logic                auxIn,        // Auxiliary input level
    input  wire logic [LANES-1:0]    patIn,        // Parallel pattern word
    input  wire logic                patValid,     // Word present
    input  wire logic                segIsPrbs,    // Mixed: word in PRBS part
    input  wire logic [8:0]          segBlock,     // Mixed: current block number
    output logic      [LANES-1:0]    patOut,       // Pattern word with errors
    output logic                     patOutValid,  // Word present on patOut
    output logic                     errPulse,     // Error was inserted
    output logic      [4:0]          errRoute      // Route index of last error
);
    import pbei_pkg::*;

    // ------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------
    generate
        if (LANES != 32)
        begin : g_bad_lanes
            $error("pattern_bit_error_injector: LANES must be 32");
        end
    endgenerate

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [39:0] pow10(input logic [3:0] n);
        logic [39:0] v;
        v = 40'h1;
        for (int i = 0; i < 12; i++)
        begin
            if (i < int'(n))
            begin
                v = 40'(v * 40'd10);
            end
        end
        return v;
    endfunction

    function automatic logic [3:0] clampMant(input logic [3:0] x, input logic [3:0] n);
        logic [3:0] hi;
        hi = (n <= EXP_MIN) ? MANT_MAX_EXP3 : MANT_MAX;
        if (x < MANT_MIN)
        begin
            return MANT_MIN;
        end
        else if (x > hi)
        begin
            return hi;
        end
        return x;
    endfunction

    function automatic logic [3:0] clampExp(input logic [3:0] n);
        if (n < EXP_MIN)
        begin
            return EXP_MIN;
        end
        else if (n > EXP_MAX)
        begin
            return EXP_MAX;
        end
        return n;
    endfunction

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic                  enable_reg;
    pbei_source_type       source_reg;
    logic                  auxInj_reg;
    logic                  single_reg;
    logic                  scan_reg;
    logic [1:0]            combine_reg;
    logic [5:0]            route_reg;
    logic [3:0]            mant_reg;
    logic [3:0]            exp_reg;
    logic                  mixedEn_reg;
    logic                  mixedPrbs_reg;
    logic [8:0]            block_reg;
    logic                  singleReq_reg;
    logic [3:0]            newExp;

    assign newExp = clampExp(regWdata[RATE_EXP_LSB +: 4]);

    // Settings are accepted whatever the enable says and used once enabled.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            enable_reg    <= 1'b0;
            source_reg    <= PBEI_SRC_INTERNAL;
            auxInj_reg    <= 1'b0;
            single_reg    <= 1'b0;
            scan_reg      <= 1'b0;
            combine_reg   <= 2'h0;
            route_reg     <= ROUTE_RESET;
            mant_reg      <= MANT_RESET;
            exp_reg       <= EXP_RESET;
            mixedEn_reg   <= 1'b0;
            mixedPrbs_reg <= 1'b0;
            block_reg     <= BLOCK_RESET;
        end
        else if (regWr)
        begin
            if (regAddr == PBEI_OFS_CTRL)
            begin
                enable_reg  <= regWdata[CTRL_ENABLE_BIT];
                source_reg  <= pbei_source_type'(regWdata[CTRL_SOURCE_LSB +: 2]);
                auxInj_reg  <= regWdata[CTRL_AUXINJ_BIT];
                single_reg  <= regWdata[CTRL_SINGLE_BIT];
                scan_reg    <= regWdata[CTRL_SCAN_BIT];
                combine_reg <= regWdata[CTRL_COMBINE_LSB +: 2];
            end
            else if (regAddr == PBEI_OFS_ROUTE)                    // [R13]
            begin
                if (regWdata < 32'(ROUTE_MIN))                     // [R11]
                begin
                    route_reg <= ROUTE_MIN;
                end
                else if (regWdata[31:0] > 32'(ROUTE_MAX))
                begin
                    route_reg <= ROUTE_MAX;
                end
                else
                begin
                    route_reg <= regWdata[5:0];
                end
            end
            else if (regAddr == PBEI_OFS_RATE)                     // [R13]
            begin
                exp_reg  <= newExp;                                // [R14]
                mant_reg <= clampMant(regWdata[RATE_MANT_LSB +: 4], newExp); // [R15]
            end
            else if (regAddr == PBEI_OFS_MIXED)
            begin
                mixedEn_reg   <= regWdata[MIXED_EN_BIT];
                mixedPrbs_reg <= regWdata[MIXED_PRBS_BIT];
                block_reg     <= regWdata[MIXED_BLOCK_LSB +: 9];
            end
        end
    end

    // A write to the single register is the operator's one-shot request.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            singleReq_reg <= 1'b0;
        end
        else
        begin
            singleReq_reg <= regWr && (regAddr == PBEI_OFS_SINGLE);
        end
    end

    // ------------------------------------------------------------------
    // Timing source selection
    // ------------------------------------------------------------------
    pbei_source_type effSource;
    logic            oneShot;
    logic            auxPrev_reg;
    logic            auxEdge;

    always_comb
    begin
        if (auxInj_reg && source_reg != PBEI_SRC_SPARE)            // [R4]
        begin
            effSource = source_reg;
        end
        else
        begin
            effSource = PBEI_SRC_INTERNAL;
        end
    end

    assign oneShot = single_reg && (effSource != PBEI_SRC_TRIGGER); // [R5]

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            auxPrev_reg <= 1'b0;
        end
        else
        begin
            auxPrev_reg <= auxIn;
        end
    end

    // The aux level is taken as clean, so no debounce is applied.
    assign auxEdge = auxIn && !auxPrev_reg;                        // [R20]

    // ------------------------------------------------------------------
    // Rate generator
    // ------------------------------------------------------------------
    // Each word carries LANES bits, so the accumulator gains x*LANES per
    // word and one slot falls due each time it passes 10^n.
    logic [39:0] acc_reg;
    logic [39:0] accSum;
    logic [39:0] limit;
    logic        rateRun;
    logic        slotDue;

    assign limit   = pow10(exp_reg);
    assign accSum  = acc_reg + 40'(mant_reg) * 40'(LANES);
    assign rateRun = enable_reg && !oneShot && (effSource != PBEI_SRC_TRIGGER); // [R16]
    assign slotDue = rateRun && patValid && (accSum >= limit);    // [R19]

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_reg <= 40'h0;
        end
        else if (!rateRun)
        begin
            acc_reg <= 40'h0;
        end
        else if (patValid)                                        // [R6]
        begin
            acc_reg <= slotDue ? accSum - limit : accSum;
        end
    end

    // ------------------------------------------------------------------
    // Pending errors
    // ------------------------------------------------------------------
    logic [3:0] pend_reg;
    logic [3:0] pendAdd;
    logic [4:0] pendSum;
    logic       regionOk;
    logic       injNow;

    always_comb
    begin
        pendAdd = 4'h0;
        if (effSource == PBEI_SRC_TRIGGER)
        begin
            pendAdd = auxEdge ? 4'h1 : 4'h0;                       // [R2]
        end
        else if (oneShot)
        begin
            pendAdd = singleReq_reg ? 4'({2'h0, combine_reg} + 4'h1) : 4'h0; // [R7] [R8]
        end
        else if (slotDue)
        begin
            pendAdd = (effSource == PBEI_SRC_GATED && !auxIn) ? 4'h0 : 4'h1; // [R3]
        end
    end

    assign regionOk = !mixedEn_reg
                   || (segIsPrbs == mixedPrbs_reg && segBlock == block_reg); // [R18]
    assign injNow   = enable_reg && patValid && regionOk && (pend_reg != 4'h0); // [R1]
    assign pendSum  = 5'(pend_reg) + 5'(pendAdd) - (injNow ? 5'h1 : 5'h0);

    // A new request in the cycle of an insertion is added, not lost.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pend_reg <= 4'h0;
        end
        else if (!enable_reg)                                      // [R1]
        begin
            pend_reg <= 4'h0;
        end
        else if (pendSum > 5'(PEND_MAX))
        begin
            pend_reg <= PEND_MAX;
        end
        else
        begin
            pend_reg <= pendSum[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Route choice and bit inversion
    // ------------------------------------------------------------------
    logic [4:0]       scan_reg5;
    logic [4:0]       routeSel;
    logic [LANES-1:0] flipMask;

    assign routeSel = scan_reg ? scan_reg5 : 5'(route_reg - 6'h1); // [R11] [R12]
    assign flipMask = injNow ? (LANES'(1) << routeSel) : '0;       // [R9] [R17]

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            scan_reg5 <= 5'h0;
        end
        else if (injNow && scan_reg)                               // [R10]
        begin
            scan_reg5 <= scan_reg5 + 5'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            patOut      <= '0;
            patOutValid <= 1'b0;
            errPulse    <= 1'b0;
            errRoute    <= 5'h0;
        end
        else
        begin
            patOut      <= patIn ^ flipMask;                       // [R19]
            patOutValid <= patValid;
            errPulse    <= injNow;
            if (injNow)
            begin
                errRoute <= routeSel;
            end
        end
    end

    // ------------------------------------------------------------------
    // Status and read port
    // ------------------------------------------------------------------
    logic [15:0] errCount_reg;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            errCount_reg <= 16'h0;
        end
        else if (injNow)
        begin
            errCount_reg <= errCount_reg + 16'h1;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            regRdata <= 32'h0;
        end
        else if (!regRd)
        begin
            regRdata <= 32'h0;
        end
        else if (regAddr == PBEI_OFS_CTRL)
        begin
            regRdata <= {24'h0, combine_reg, scan_reg, single_reg, auxInj_reg,
                         source_reg, enable_reg};
        end
        else if (regAddr == PBEI_OFS_ROUTE)
        begin
            regRdata <= {26'h0, route_reg};
        end
        else if (regAddr == PBEI_OFS_RATE)
        begin
            regRdata <= {20'h0, exp_reg, 4'h0, mant_reg};
        end
        else if (regAddr == PBEI_OFS_MIXED)
        begin
            regRdata <= {7'h0, block_reg, 14'h0, mixedPrbs_reg, mixedEn_reg};
        end
        else if (regAddr == PBEI_OFS_STATUS)
        begin
            regRdata <= {4'h0, pend_reg, 3'h0, scan_reg5, errCount_reg};
        end
        else
        begin
            regRdata <= 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    chk_disabled_silent: assert property (!enable_reg |=> !errPulse) // [R1]
        else $error("error inserted while insertion disabled");

    chk_trigger_edge: assert property (enable_reg && effSource == PBEI_SRC_TRIGGER // [R2]
            && auxIn && !auxPrev_reg && pend_reg == 4'h0
            ##1 (enable_reg && patValid && regionOk) |=> errPulse)
        else $error("trigger edge did not insert an error");

    chk_gated_low: assert property (slotDue && effSource == PBEI_SRC_GATED && !auxIn // [R3]
            |-> pendAdd == 4'h0)
        else $error("gated slot taken while aux low");

    chk_aux_select: assert property (!auxInj_reg |-> effSource == PBEI_SRC_INTERNAL) // [R4]
        else $error("external source used without aux injection");

    chk_single_count: assert property (enable_reg && oneShot && singleReq_reg // [R8]
            && pend_reg == 4'h0 && !injNow
            |=> pend_reg == 4'($past(combine_reg)) + 4'h1)
        else $error("one-shot request queued wrong count");

    chk_oneshot_norate: assert property (oneShot |-> !slotDue)    // [R16]
        else $error("rate slot fired in one-shot mode");

    chk_one_bit: assert property (errPulse |-> $onehot(patOut ^ $past(patIn))) // [R17]
        else $error("error did not flip exactly one bit");

    chk_no_err_clean: assert property ($past(nrst) && !errPulse // [R17]
            |-> patOut == $past(patIn))
        else $error("pattern altered without an error");

    chk_fixed_route: assert property (injNow && !scan_reg // [R11]
            |=> errRoute == 5'($past(route_reg) - 6'h1))
        else $error("fixed route not honoured");

    chk_scan_step: assert property (injNow && scan_reg // [R10]
            |=> scan_reg5 == $past(scan_reg5) + 5'h1)
        else $error("scan route did not advance");

    chk_region_gate: assert property (mixedEn_reg && segBlock != block_reg // [R18]
            |-> !injNow)
        else $error("error inserted outside chosen block");

    chk_rate_range: assert property (exp_reg >= EXP_MIN && exp_reg <= EXP_MAX // [R14] [R15]
            && mant_reg >= MANT_MIN && mant_reg <= MANT_MAX
            && (exp_reg != EXP_MIN || mant_reg <= MANT_MAX_EXP3))
        else $error("rate setting out of range");

endmodule

`default_nettype wire

/* sim/pbei_rx_model.sv */
/*
 * Receiver model for the pattern bit error injector: it compares each
 * received word with the word that was sent and counts the inverted bits.
 * Assumes refIn is the injector's patIn, sampled on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module pbei_rx_model (
    input  wire logic        clk,         // Pattern clock
    input  wire logic        nrst,        // Async reset, active low
    input  wire logic [31:0] refIn,       // Word sent into the injector
    input  wire logic [31:0] patOut,      // Word received
    input  wire logic        patOutValid, // Received word present
    output logic      [15:0] bitErrs,     // Inverted bits seen so far
    output logic      [4:0]  lastLane,    // Lane of the last inverted bit
    output logic             multiHit     // A word held more than one inverted bit
);
    logic [31:0] refReg;
    logic [31:0] diff;

    assign diff = patOut ^ refReg;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            refReg <= 32'h0;
        else
            refReg <= refIn;
    end

    // A corrupted bit shows as a single inverted lane of the word.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bitErrs  <= 16'h0;
            lastLane <= 5'h0;
            multiHit <= 1'b0;
        end
        else if (patOutValid && diff != 32'h0)
        begin
            bitErrs  <= bitErrs + 16'($countones(diff));
            multiHit <= multiHit | ($countones(diff) != 1);
            for (int k = 0; k < 32; k++)
                if (diff[k])
                    lastLane <= 5'(k);
        end
    end
endmodule

`default_nettype wire

/* sim/pattern_bit_error_injector_tb.sv */
/*
 * Testbench for the pattern bit error injector: register access and every
 * error timing, route and insertion mode.
 * Assumes the receiver model beside the design and a 25 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin errorCnt++; \
    $display("mismatch at %0t: %s", $time, m); end end

module pattern_bit_error_injector_tb;
    import pbei_pkg::*;
    logic        clk, nrst, regWr, regRd, auxIn, patValid, segIsPrbs;
    logic        patOutValid, errPulse, multiHit;
    logic [7:0]  regAddr;
    logic [31:0] regWdata, regRdata, patIn, patOut;
    logic [8:0]  segBlock;
    logic [4:0]  errRoute, lastLane;
    logic [15:0] bitErrs, cyc;
    logic [4:0]  laneQ[$];
    int          errorCnt, compares, errSeen;

    pattern_bit_error_injector pattern_bit_error_injector_i (.clk(clk), .nrst(nrst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .auxIn(auxIn), .patIn(patIn), .patValid(patValid),
        .segIsPrbs(segIsPrbs), .segBlock(segBlock), .patOut(patOut),
        .patOutValid(patOutValid), .errPulse(errPulse), .errRoute(errRoute));
    pbei_rx_model pbei_rx_model_i (.clk(clk), .nrst(nrst), .refIn(patIn), .patOut(patOut),
        .patOutValid(patOutValid), .bitErrs(bitErrs), .lastLane(lastLane),
        .multiHit(multiHit));

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc   <= cyc + 16'h1;
        patIn <= {cyc, ~cyc};
        if (errPulse === 1'b1)
        begin
            errSeen <= errSeen + 1;
            laneQ.push_back(errRoute);
        end
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        @(posedge clk);
        `CHK(regRdata, e, "register read")
    endtask

    // Optional aux pulses are clean two-cycle highs, then the errors are counted.
    task automatic span(input int n, input int pulses, input int lo, input int hi);
        int base;
        base = errSeen;
        repeat (pulses)
        begin
            @(posedge clk);
            auxIn <= 1'b1;
            repeat (2) @(posedge clk);
            auxIn <= 1'b0;
            repeat (4) @(posedge clk);
        end
        repeat (n) @(posedge clk);
        `CHK((errSeen - base >= lo) && (errSeen - base <= hi), 1'b1, "error count")
    endtask

    task automatic final_report;
        $display("errors %0d compares %0d", errorCnt, compares);
        if (errorCnt == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        errorCnt++;
        $display("mismatch at %0t: run did not finish", $time);
        final_report;
    end

    initial
    begin
        nrst = 1'b0;
        regWr = 1'b0;
        regRd = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        auxIn = 1'b0;
        patValid = 1'b1;
        segIsPrbs = 1'b0;
        segBlock = 9'h001;
        cyc = 16'h0;
        patIn = 32'h0;
        errSeen = 0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rdchk(PBEI_OFS_CTRL, 32'h0);
        rdchk(PBEI_OFS_ROUTE, 32'h1);
        rdchk(PBEI_OFS_RATE, 32'h0601);
        rdchk(PBEI_OFS_MIXED, 32'h0001_0000);
        rdchk(8'h18, 32'h0);
        wr(PBEI_OFS_ROUTE, 32'h3f);
        rdchk(PBEI_OFS_ROUTE, 32'h20);
        wr(PBEI_OFS_RATE, 32'h0309);
        rdchk(PBEI_OFS_RATE, 32'h0305);
        wr(PBEI_OFS_ROUTE, 32'h5);
        wr(PBEI_OFS_CTRL, 32'h11);
        wr(PBEI_OFS_SINGLE, 32'h1);
        span(20, 0, 1, 1);
        `CHK(errRoute, 5'h04, "fixed route")
        `CHK(lastLane, 5'h04, "inverted lane")
        wr(PBEI_OFS_CTRL, 32'h91);
        wr(PBEI_OFS_SINGLE, 32'h1);
        span(20, 0, 3, 3);
        laneQ.delete();
        wr(PBEI_OFS_CTRL, 32'hb1);
        wr(PBEI_OFS_SINGLE, 32'h1);
        span(20, 0, 3, 3);
        `CHK(laneQ[1], laneQ[0] + 5'h1, "scan step")
        `CHK(laneQ[2], laneQ[1] + 5'h1, "scan step")
        wr(PBEI_OFS_CTRL, 32'h01);
        span(100, 0, 13, 17);
        wr(PBEI_OFS_CTRL, 32'h11);
        repeat (4) @(posedge clk);
        span(100, 0, 0, 0);
        wr(PBEI_OFS_CTRL, 32'h05);
        span(100, 0, 13, 17);
        wr(PBEI_OFS_CTRL, 32'h0d);
        // A slot queued under the previous setting still lands; let it drain first.
        repeat (4) @(posedge clk);
        span(100, 0, 0, 0);
        auxIn <= 1'b1;
        span(100, 0, 13, 17);
        auxIn <= 1'b0;
        wr(PBEI_OFS_CTRL, 32'h0a);
        repeat (4) @(posedge clk);
        span(10, 3, 0, 0);
        wr(PBEI_OFS_CTRL, 32'h0b);
        span(10, 3, 3, 3);
        wr(PBEI_OFS_MIXED, 32'h0003_0003);
        segIsPrbs <= 1'b1;
        wr(PBEI_OFS_CTRL, 32'h11);
        wr(PBEI_OFS_SINGLE, 32'h1);
        span(20, 0, 0, 0);
        segBlock <= 9'h003;
        span(10, 0, 1, 1);
        `CHK(bitErrs, 16'(errSeen), "inverted bits")
        `CHK(multiHit, 1'b0, "one bit per error")
        rdchk(PBEI_OFS_STATUS, {16'h0003, 16'(errSeen)});
        final_report;
    end
endmodule

`default_nettype wire
